// ==== rtl/dsr_pkg.sv ====
// package: addresses, bit positions and reset values of the debug unit's
// vector remap control and stall cause status registers.
// assumes one core clock and accesses from the single-wire link controller.
//
// Notes on behaviour
// R1 - remap control resets to all zero
// R2 - host writes zero to remap bits 7:3
// R3 - rom remap bit redirects vector fetches
// R4 - ram remap bit redirects vector fetches
// R5 - host writes zero to remap bit 1
// R6 - status register resets with only bit 4
// R7 - step enable bit is read write
// R8 - step flag hardware set, writes ignored
// R9 - reset flag set after reset, stall release clears
// R10 - direction flag: zero write, one read
// R11 - direction flag follows next data break, ignores writes
// R12 - second break flag set on hit, released
// R13 - first break flag set on hit, released
// R14 - stall release clears the cause flags
// R15 - step plus break sets both flags
// R16 - reserved bits read zero, ignore writes
package dsr_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int VEC_W = 24;

	localparam logic [ADDR_W-1:0] VRC_ADDR = 16'h7f97;
	localparam logic [ADDR_W-1:0] CSR_ADDR = 16'h7f98;

	localparam logic [DATA_W-1:0] VRC_RESET = 8'h00;
	localparam logic [DATA_W-1:0] CSR_RESET = 8'h10;

	// remap control fields
	localparam int VRC_RAM_BIT = 0;
	localparam int VRC_ROM_BIT = 2;
	localparam logic [DATA_W-1:0] VRC_WMASK = 8'h05;

	// stall cause status fields
	localparam int CSR_BK1_BIT = 1;
	localparam int CSR_BK2_BIT = 2;
	localparam int CSR_DIR_BIT = 3;
	localparam int CSR_RST_BIT = 4;
	localparam int CSR_STF_BIT = 5;
	localparam int CSR_STE_BIT = 6;

	// vector table bases; rom and ram bases are product choices
	localparam logic [VEC_W-1:0] PROG_VEC_BASE = 24'h00_8000;
	localparam logic [VEC_W-1:0] ROM_VEC_DEFAULT = 24'h00_6000;
	localparam logic [VEC_W-1:0] RAM_VEC_DEFAULT = 24'h00_0000;

endpackage : dsr_pkg

// ==== rtl/dsr_vec_sel.sv ====
// vector table base selector: turns the two remap bits into a registered base.
// assumes remap bits come from flip-flops on the same clock.
module dsr_vec_sel
	import dsr_pkg::*;
#(
	parameter logic [dsr_pkg::VEC_W-1:0] ROM_BASE = dsr_pkg::ROM_VEC_DEFAULT,
	parameter logic [dsr_pkg::VEC_W-1:0] RAM_BASE = dsr_pkg::RAM_VEC_DEFAULT
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic vector_to_rom,
	input wire logic vector_to_ram,
	output logic [dsr_pkg::VEC_W-1:0] vector_base
);

	logic [VEC_W-1:0] next_vector_base;

	////////////////////////////////////////////////////////////////////////
	// ram remap takes precedence when both are set
	always_comb begin
		if (vector_to_ram) begin
			next_vector_base = RAM_BASE; // R4
		end else if (vector_to_rom) begin
			next_vector_base = ROM_BASE; // R3
		end else begin
			next_vector_base = PROG_VEC_BASE; // R3
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			vector_base <= PROG_VEC_BASE;
		end else begin
			vector_base <= next_vector_base;
		end
	end

endmodule : dsr_vec_sel

// ==== rtl/dsr_regs.sv ====
// debug unit: vector remap control and stall cause status registers.
// assumes link reads and writes, stall events and stall release are
// single-cycle pulses from logic on mclk.
module dsr_regs
	import dsr_pkg::*;
#(
	parameter logic [dsr_pkg::VEC_W-1:0] ROM_BASE = dsr_pkg::ROM_VEC_DEFAULT,
	parameter logic [dsr_pkg::VEC_W-1:0] RAM_BASE = dsr_pkg::RAM_VEC_DEFAULT
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic link_wr,
	input wire logic link_rd,
	input wire logic [dsr_pkg::ADDR_W-1:0] link_addr,
	input wire logic [dsr_pkg::DATA_W-1:0] link_wdata,
	output logic [dsr_pkg::DATA_W-1:0] link_rdata,
	output logic link_rvalid,
	input wire logic step_stall,
	input wire logic reset_stall,
	input wire logic first_break_hit,
	input wire logic second_break_hit,
	input wire logic data_break,
	input wire logic break_is_read,
	input wire logic stall_release,
	output logic vector_to_rom,
	output logic vector_to_ram,
	output logic single_step_enable,
	output logic [dsr_pkg::VEC_W-1:0] vector_base
);

	logic [DATA_W-1:0] next_link_rdata;
	logic next_link_rvalid;
	logic next_vector_to_rom;
	logic next_vector_to_ram;
	logic next_single_step_enable;
	logic single_step_flag;
	logic next_single_step_flag;
	logic reset_flag;
	logic next_reset_flag;
	logic break_direction_flag;
	logic next_break_direction_flag;
	logic second_break_flag;
	logic next_second_break_flag;
	logic first_break_flag;
	logic next_first_break_flag;
	logic vrc_wr;
	logic csr_wr;
	logic any_break;
	logic [DATA_W-1:0] vrc_value;
	logic [DATA_W-1:0] csr_value;

	////////////////////////////////////////////////////////////////////////
	// cause flag update: a set in the release cycle wins
	function automatic logic cause_next(
		input logic cur,
		input logic set,
		input logic clr
	);
		cause_next = set | (cur & ~clr);
	endfunction : cause_next

	////////////////////////////////////////////////////////////////////////
	// address decode
	assign vrc_wr = link_wr && (link_addr == VRC_ADDR);
	assign csr_wr = link_wr && (link_addr == CSR_ADDR);
	assign any_break = first_break_hit | second_break_hit;

	// reserved positions assemble as zero
	always_comb begin
		vrc_value = '0; // R16
		vrc_value[VRC_ROM_BIT] = vector_to_rom;
		vrc_value[VRC_RAM_BIT] = vector_to_ram;
		csr_value = '0; // R16
		csr_value[CSR_STE_BIT] = single_step_enable;
		csr_value[CSR_STF_BIT] = single_step_flag;
		csr_value[CSR_RST_BIT] = reset_flag;
		csr_value[CSR_DIR_BIT] = break_direction_flag;
		csr_value[CSR_BK2_BIT] = second_break_flag;
		csr_value[CSR_BK1_BIT] = first_break_flag;
	end

	////////////////////////////////////////////////////////////////////////
	// remap control register
	always_comb begin
		next_vector_to_rom = vector_to_rom;
		next_vector_to_ram = vector_to_ram;
		if (vrc_wr) begin
			// only writable positions are kept
			next_vector_to_rom = link_wdata[VRC_ROM_BIT] & VRC_WMASK[VRC_ROM_BIT]; // R3
			next_vector_to_ram = link_wdata[VRC_RAM_BIT] & VRC_WMASK[VRC_RAM_BIT]; // R4
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			vector_to_rom <= VRC_RESET[VRC_ROM_BIT]; // R1
			vector_to_ram <= VRC_RESET[VRC_RAM_BIT]; // R1
		end else begin
			vector_to_rom <= next_vector_to_rom;
			vector_to_ram <= next_vector_to_ram;
		end
	end

	dsr_vec_sel #(
		.ROM_BASE(ROM_BASE),
		.RAM_BASE(RAM_BASE)
	) u_vec_sel (
		.mclk(mclk),
		.rst_n(rst_n),
		.vector_to_rom(vector_to_rom),
		.vector_to_ram(vector_to_ram),
		.vector_base(vector_base)
	);

	////////////////////////////////////////////////////////////////////////
	// stall cause status register
	always_comb begin
		next_single_step_enable = single_step_enable;
		if (csr_wr) begin
			next_single_step_enable = link_wdata[CSR_STE_BIT]; // R7
		end
		// flag bits ignore link writes entirely
		next_single_step_flag = cause_next(single_step_flag,
			step_stall & single_step_enable, stall_release); // R8 R15
		next_reset_flag = cause_next(reset_flag, reset_stall, stall_release); // R9 R14
		next_second_break_flag = cause_next(second_break_flag,
			second_break_hit, stall_release); // R12 R14 R15
		next_first_break_flag = cause_next(first_break_flag,
			first_break_hit, stall_release); // R13 R14 R15
		next_break_direction_flag = break_direction_flag;
		if (any_break && data_break) begin
			next_break_direction_flag = break_is_read; // R10 R11
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			single_step_enable <= CSR_RESET[CSR_STE_BIT]; // R6
			single_step_flag <= CSR_RESET[CSR_STF_BIT]; // R6
			reset_flag <= CSR_RESET[CSR_RST_BIT]; // R6
			break_direction_flag <= CSR_RESET[CSR_DIR_BIT]; // R6
			second_break_flag <= CSR_RESET[CSR_BK2_BIT]; // R6
			first_break_flag <= CSR_RESET[CSR_BK1_BIT]; // R6
		end else begin
			single_step_enable <= next_single_step_enable;
			single_step_flag <= next_single_step_flag;
			reset_flag <= next_reset_flag;
			break_direction_flag <= next_break_direction_flag;
			second_break_flag <= next_second_break_flag;
			first_break_flag <= next_first_break_flag;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read path: data one cycle after the read strobe, held until next read
	always_comb begin
		next_link_rvalid = link_rd;
		next_link_rdata = link_rdata;
		if (link_rd) begin
			if (link_addr == VRC_ADDR) begin
				next_link_rdata = vrc_value;
			end else if (link_addr == CSR_ADDR) begin
				next_link_rdata = csr_value;
			end else begin
				next_link_rdata = '0;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			link_rdata <= '0;
			link_rvalid <= 1'b0;
		end else begin
			link_rdata <= next_link_rdata;
			link_rvalid <= next_link_rvalid;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	property p_vrc_reset_zero;
		@(posedge mclk) $rose(rst_n) |-> (vector_to_rom == 1'b0) && (vector_to_ram == 1'b0);
	endproperty
	a_vrc_reset_zero: assert property (p_vrc_reset_zero) // R1
		else $error("remap control not zero after reset");

	property p_rom_remap_base;
		@(posedge mclk) disable iff (!rst_n)
		vector_to_rom && !vector_to_ram ##1 vector_to_rom && !vector_to_ram
			|-> vector_base == ROM_BASE;
	endproperty
	a_rom_remap_base: assert property (p_rom_remap_base) // R3
		else $error("rom remap does not select rom base");

	property p_ram_remap_base;
		@(posedge mclk) disable iff (!rst_n)
		vector_to_ram ##1 vector_to_ram |-> vector_base == RAM_BASE;
	endproperty
	a_ram_remap_base: assert property (p_ram_remap_base) // R4
		else $error("ram remap does not select ram base");

	property p_prog_base;
		@(posedge mclk) disable iff (!rst_n)
		!vector_to_ram && !vector_to_rom ##1 !vector_to_ram && !vector_to_rom
			|-> vector_base == PROG_VEC_BASE;
	endproperty
	a_prog_base: assert property (p_prog_base) // R3 R4
		else $error("no remap but base is not program memory");

	property p_csr_reset_value;
		@(posedge mclk) $rose(rst_n) |-> csr_value == CSR_RESET;
	endproperty
	a_csr_reset_value: assert property (p_csr_reset_value) // R6
		else $error("status register reset value wrong");

	property p_step_enable_write;
		@(posedge mclk) disable iff (!rst_n)
		csr_wr |=> single_step_enable == $past(link_wdata[CSR_STE_BIT]);
	endproperty
	a_step_enable_write: assert property (p_step_enable_write) // R7
		else $error("step enable did not take written value");

	property p_step_flag_set;
		@(posedge mclk) disable iff (!rst_n)
		step_stall && single_step_enable |=> single_step_flag;
	endproperty
	a_step_flag_set: assert property (p_step_flag_set) // R8
		else $error("step stall did not set step flag");

	property p_step_off_ignored;
		@(posedge mclk) disable iff (!rst_n)
		step_stall && !single_step_enable && !stall_release |=> $stable(single_step_flag);
	endproperty
	a_step_off_ignored: assert property (p_step_off_ignored) // R7
		else $error("step stall changed flag while stepping off");

	property p_step_release_clears;
		@(posedge mclk) disable iff (!rst_n)
		stall_release && !step_stall |=> !single_step_flag;
	endproperty
	a_step_release_clears: assert property (p_step_release_clears) // R8
		else $error("stall release left step flag set");

	property p_reset_flag_set;
		@(posedge mclk) disable iff (!rst_n)
		reset_stall |=> reset_flag;
	endproperty
	a_reset_flag_set: assert property (p_reset_flag_set) // R9
		else $error("reset stall did not set reset flag");

	property p_flags_ignore_write;
		@(posedge mclk) disable iff (!rst_n)
		csr_wr && !step_stall && !reset_stall && !any_break && !stall_release
			|=> csr_value[5:1] == $past(csr_value[5:1]);
	endproperty
	a_flags_ignore_write: assert property (p_flags_ignore_write) // R8 R9 R11 R12 R13
		else $error("write changed a read-only flag");

	property p_release_clears;
		@(posedge mclk) disable iff (!rst_n)
		stall_release && !reset_stall && !any_break
			|=> !reset_flag && !first_break_flag && !second_break_flag;
	endproperty
	a_release_clears: assert property (p_release_clears) // R9 R12 R13 R14
		else $error("stall release left a cause flag set");

	property p_set_beats_release;
		@(posedge mclk) disable iff (!rst_n)
		stall_release && first_break_hit |=> first_break_flag;
	endproperty
	a_set_beats_release: assert property (p_set_beats_release) // R13
		else $error("break hit lost in release cycle");

	property p_direction_capture;
		@(posedge mclk) disable iff (!rst_n)
		any_break && data_break |=> break_direction_flag == $past(break_is_read);
	endproperty
	a_direction_capture: assert property (p_direction_capture) // R10
		else $error("direction flag did not capture access type");

	property p_direction_survives_release;
		@(posedge mclk) disable iff (!rst_n)
		stall_release && !any_break |=> $stable(break_direction_flag);
	endproperty
	a_direction_survives_release: assert property (p_direction_survives_release) // R11
		else $error("direction flag changed on stall release");

	property p_step_and_break;
		@(posedge mclk) disable iff (!rst_n)
		step_stall && single_step_enable && second_break_hit
			|=> single_step_flag && second_break_flag;
	endproperty
	a_step_and_break: assert property (p_step_and_break) // R15
		else $error("step with break did not set both flags");

	property p_reserved_zero;
		@(posedge mclk) disable iff (!rst_n)
		link_rvalid |-> (($past(link_addr) == VRC_ADDR) ?
			((link_rdata & ~VRC_WMASK) == 8'h00) :
			((link_rdata[7] == 1'b0) && (link_rdata[0] == 1'b0)));
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) // R16
		else $error("reserved read bit not zero");

	property p_read_latency;
		@(posedge mclk) disable iff (!rst_n)
		link_rd && link_addr == VRC_ADDR |=> link_rvalid && link_rdata == $past(vrc_value);
	endproperty
	a_read_latency: assert property (p_read_latency) // R16
		else $error("remap read data wrong or late");

endmodule : dsr_regs

// ==== testbench/dsr_host.sv ====
// debug host model: issues register reads and writes on the link strobes.
// assumes the registers answer reads one mclk later with link_rvalid.
module dsr_host
	import dsr_pkg::*;
(
	input wire logic mclk,
	output logic link_wr,
	output logic link_rd,
	output logic [dsr_pkg::ADDR_W-1:0] link_addr,
	output logic [dsr_pkg::DATA_W-1:0] link_wdata,
	input wire logic [dsr_pkg::DATA_W-1:0] link_rdata,
	input wire logic link_rvalid
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		link_wr = 1'b0;
		link_rd = 1'b0;
		link_addr = 16'h0000;
		link_wdata = 8'h00;
	end
	////////////////////////////////////////////////////////////////
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk) #1;
		link_wr = 1'b1;
		link_addr = a;
		// reserved remap bits always sent as zero
		link_wdata = (a == VRC_ADDR) ? (d & VRC_WMASK) : d;
		@(posedge mclk) #1;
		link_wr = 1'b0;
		// released lines show garbage, not the old value
		link_addr = ~link_addr;
		link_wdata = ~link_wdata;
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
		@(posedge mclk) #1;
		link_rd = 1'b1;
		link_addr = a;
		@(posedge mclk) #1;
		link_rd = 1'b0;
		link_addr = ~link_addr;
		d = link_rdata;
		v = link_rvalid;
	endtask : rd
endmodule : dsr_host

// ==== testbench/debug_stall_cause_and_vector_remap_test.sv ====
// bench for the remap control and stall cause status registers.
// assumes dsr_host drives the link; stall events are driven here.
module debug_stall_cause_and_vector_remap_test;
	timeunit 1ns;
	timeprecision 100ps;
	import dsr_pkg::*;
	localparam logic [23:0] ROMB = 24'h01_2300;
	localparam logic [23:0] RAMB = 24'h00_4500;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic link_wr, link_rd, link_rvalid;
	logic [15:0] link_addr;
	logic [7:0] link_wdata, link_rdata;
	logic step_stall = 1'b0, reset_stall = 1'b0, stall_release = 1'b0;
	logic first_break_hit = 1'b0, second_break_hit = 1'b0;
	logic data_break = 1'b0, break_is_read = 1'b0;
	logic vector_to_rom, vector_to_ram, single_step_enable;
	logic [23:0] vector_base;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	always #25 mclk = ~mclk;
	dsr_regs #(.ROM_BASE(ROMB), .RAM_BASE(RAMB)) u_dut (
		.mclk(mclk), .rst_n(rst_n), .link_wr(link_wr), .link_rd(link_rd),
		.link_addr(link_addr), .link_wdata(link_wdata), .link_rdata(link_rdata),
		.link_rvalid(link_rvalid), .step_stall(step_stall), .reset_stall(reset_stall),
		.first_break_hit(first_break_hit), .second_break_hit(second_break_hit),
		.data_break(data_break), .break_is_read(break_is_read),
		.stall_release(stall_release), .vector_to_rom(vector_to_rom),
		.vector_to_ram(vector_to_ram), .single_step_enable(single_step_enable),
		.vector_base(vector_base));
	dsr_host u_host (
		.mclk(mclk), .link_wr(link_wr), .link_rd(link_rd), .link_addr(link_addr),
		.link_wdata(link_wdata), .link_rdata(link_rdata), .link_rvalid(link_rvalid));
	////////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic rdchk(input logic [15:0] a, input logic [7:0] exp, input string name);
		logic [7:0] d;
		logic v;
		u_host.rd(a, d, v);
		chk({name, " rvalid"}, {23'h0, v}, 24'h00_0001);
		chk(name, {16'h0, d}, {16'h0, exp});
	endtask : rdchk
	// one-cycle event pulse: {step, reset, first, second}, data, read
	task automatic ev(input logic [3:0] e, input logic d, input logic r);
		@(posedge mclk) #1;
		{step_stall, reset_stall, first_break_hit, second_break_hit} = e;
		data_break = d;
		break_is_read = r;
		@(posedge mclk) #1;
		{step_stall, reset_stall, first_break_hit, second_break_hit} = 4'h0;
		{data_break, break_is_read} = 2'b11;
	endtask : ev
	task automatic release_stall();
		@(posedge mclk) #1;
		stall_release = 1'b1;
		@(posedge mclk) #1;
		stall_release = 1'b0;
	endtask : release_stall
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk("base", vector_base, PROG_VEC_BASE);
		rdchk(VRC_ADDR, 8'h00, "remap");
		rdchk(CSR_ADDR, 8'h10, "status");
		rdchk(16'h7f99, 8'h00, "unmapped");
	endtask : t_reset
	task automatic t_remap();
		u_host.wr(VRC_ADDR, 8'h04);
		chk("rom bit", {23'h0, vector_to_rom}, 24'h00_0001);
		@(posedge mclk) #1;
		chk("rom base", vector_base, ROMB);
		u_host.wr(VRC_ADDR, 8'h01);
		@(posedge mclk) #1;
		chk("ram base", vector_base, RAMB);
		rdchk(VRC_ADDR, 8'h01, "remap rb");
		u_host.wr(VRC_ADDR, 8'h00);
		@(posedge mclk) #1;
		chk("prog base", vector_base, PROG_VEC_BASE);
	endtask : t_remap
	task automatic t_step();
		u_host.wr(CSR_ADDR, 8'hff);
		chk("step en", {23'h0, single_step_enable}, 24'h00_0001);
		rdchk(CSR_ADDR, 8'h50, "ro bits");
		ev(4'b1010, 1'b0, 1'b0);
		rdchk(CSR_ADDR, 8'h72, "step+bk1");
		release_stall();
		rdchk(CSR_ADDR, 8'h40, "released");
		ev(4'b0100, 1'b0, 1'b0);
		rdchk(CSR_ADDR, 8'h50, "rst flag");
		release_stall();
		u_host.wr(CSR_ADDR, 8'h00);
		ev(4'b1000, 1'b0, 1'b0);
		rdchk(CSR_ADDR, 8'h00, "step off");
	endtask : t_step
	task automatic t_break();
		ev(4'b0001, 1'b1, 1'b1);
		rdchk(CSR_ADDR, 8'h0c, "bk2 read");
		release_stall();
		rdchk(CSR_ADDR, 8'h08, "dir kept");
		ev(4'b0010, 1'b1, 1'b0);
		rdchk(CSR_ADDR, 8'h02, "bk1 write");
		u_host.wr(CSR_ADDR, 8'h0c);
		ev(4'b0001, 1'b0, 1'b1);
		rdchk(CSR_ADDR, 8'h06, "fetch brk");
		release_stall();
		rdchk(CSR_ADDR, 8'h00, "all clear");
	endtask : t_break
	// events in the release cycle: the set must win
	task automatic t_overlap();
		u_host.wr(CSR_ADDR, 8'h40);
		@(posedge mclk) #1;
		stall_release = 1'b1;
		{step_stall, reset_stall, first_break_hit, second_break_hit} = 4'b1011;
		{data_break, break_is_read} = 2'b11;
		@(posedge mclk) #1;
		stall_release = 1'b0;
		{step_stall, reset_stall, first_break_hit, second_break_hit} = 4'h0;
		rdchk(CSR_ADDR, 8'h6e, "set wins");
		release_stall();
		rdchk(CSR_ADDR, 8'h48, "set cleared");
	endtask : t_overlap
	// both remap bits, then a reset in mid-run
	task automatic t_rst2();
		u_host.wr(VRC_ADDR, 8'h05);
		@(posedge mclk) #1;
		chk("both base", vector_base, RAMB);
		chk("ram bit", {23'h0, vector_to_ram}, 24'h00_0001);
		rst_n = 1'b0;
		repeat (3) @(posedge mclk);
		#1 rst_n = 1'b1;
		chk("rst base", vector_base, PROG_VEC_BASE);
		chk("rst step en", {23'h0, single_step_enable}, 24'h00_0000);
		rdchk(VRC_ADDR, 8'h00, "remap rst");
		rdchk(CSR_ADDR, 8'h10, "status rst");
	endtask : t_rst2
	////////////////////////////////////////////////////////////////
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			stop_test();
		end
	end
	initial begin
		repeat (12) @(posedge mclk);
		#1 rst_n = 1'b1;
		t_reset();
		t_remap();
		t_step();
		t_break();
		t_overlap();
		t_rst2();
		stop_test();
	end
endmodule : debug_stall_cause_and_vector_remap_test
